//--- bench/link_capabilities_register_tb.sv
// Self-checking bench for the link capability register bank
`timescale 1ns/1ps

module link_capabilities_register_tb;
   import lcap_pkg::*;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] expUp;
      logic [31:0] expDn;
   } lcap_row_s;

   logic              clk = 1'b0;
   logic              resetn = 1'b1; // Falls at time zero for a clean reset edge
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWdata = '0;
   logic              regWr = 1'b0;
   logic              regRd = 1'b0;
   logic [DATA_W-1:0] rdUp;
   logic [DATA_W-1:0] rdDn;
   logic [5:0]        trainUp;
   logic [5:0]        trainDn;
   logic              shareUp;
   logic              shareDn;
   int                mismatches = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   lcap_row_s         rows [4];
   logic [5:0]        laneCodes [6] = '{6'h00, 6'h03, 6'h08, 6'h01, 6'h04, 6'h02};

   // Upstream x4 port and downstream x2 port share one bus
   lcap_regs #(.PORT_INDEX(8'h00), .PHYS_LANES(6'h04)) i_lcap_regs (
      .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(rdUp), .trainLaneCount(trainUp), .sharedRefclk(shareUp));
   lcap_regs #(.PORT_INDEX(8'h03), .PHYS_LANES(6'h02)) i_lcap_regs_dn (
      .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(rdDn), .trainLaneCount(trainDn), .sharedRefclk(shareDn));

   always #20 clk = ~clk;

   // Expected capability word built field by field
   function automatic logic [31:0] capw(input logic [7:0] p, input logic [5:0] ln,
      input logic [2:0] sl, input logic [2:0] dl, input logic rc, input logic sd, input logic la);
      lcap_cap_s c;
      c = '{portIndex: p, rsvd: 3'h0, linkActiveReportCap: la, surpriseDownReportCap: sd,
            refclkRemovalCapable: rc, deepStateExitLatency: dl, shortExitLatency: sl,
            activePowerStateSupport: 2'h3, maxLaneCount: ln, supportedSpeedCode: 4'h1};
      return c;
   endfunction : capw

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Strobe left high so a following access may come with no gap
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      regWr <= 1'b1;
      regRd <= 1'b0;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] eu, input logic [31:0] ed);
      regRd <= 1'b1;
      regWr <= 1'b0;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      chk(rdUp, eu);
      chk(rdDn, ed);
   endtask : rd

   task automatic idle();
      regWr <= 1'b0;
      regRd <= 1'b0;
      @(posedge clk);
   endtask : idle

   // Hold reset four cycles, then wait past the two-flop release
   task automatic doReset();
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(32'(trainUp), 32'h0000_0001);
      chk({30'h0, shareDn, shareUp}, 32'h0000_0000);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk(32'(trainUp), 32'h0000_0004);
      chk(32'(trainDn), 32'h0000_0002);
   endtask : doReset

   task automatic stop_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // Hang guard, far beyond the 54 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         $display("[ERR] %0t ns: run did not finish in time", $time);
         stop_test();
      end
   end

   initial begin
      rows = '{'{12'h04c, capw(8'h00, 6'h04, 3'h5, 3'h2, 1'b0, 1'b0, 1'b0),
                          capw(8'h03, 6'h02, 3'h5, 3'h2, 1'b0, 1'b1, 1'b1)},
               '{12'h050, 32'h0000_0000, 32'h0000_0000},
               '{12'h400, 32'h0000_0000, 32'h0000_0000},
               '{12'h123, 32'h0000_0000, 32'h0000_0000}};
      doReset();
      // Reset values of every mapped place and one unmapped one
      foreach (rows[i]) begin
         rd(rows[i].addr, rows[i].expUp, rows[i].expDn);
      end
      // Locked: writes to the capability word are dropped
      wr(12'h04c, 32'hFFFF_FFFF);
      wr(12'h123, 32'hFFFF_FFFF);
      rd(12'h04c, rows[0].expUp, rows[0].expDn);
      rd(12'h123, 32'h0000_0000, 32'h0000_0000);
      // Unlocked: all ones, read back with no gap
      wr(12'h400, 32'h0000_0001);
      wr(12'h04c, 32'hFFFF_FFFF);
      rd(12'h04c, capw(8'h00, 6'h3F, 3'h5, 3'h7, 1'b1, 1'b0, 1'b0),
                  capw(8'h03, 6'h02, 3'h5, 3'h7, 1'b1, 1'b1, 1'b1));
      chk(32'(trainUp), 32'h0000_0001);
      // Six lane codes, valid and reserved
      foreach (laneCodes[i]) begin
         wr(12'h04c, {22'h0, laneCodes[i], 4'h0});
         idle();
         #1;
         chk(32'(trainUp), (laneCodes[i] == 6'h01 || laneCodes[i] == 6'h02 ||
             laneCodes[i] == 6'h04) ? 32'(laneCodes[i]) : 32'h0000_0001);
         chk(32'(trainDn), 32'h0000_0002);
         rd(12'h04c, capw(8'h00, laneCodes[i], 3'h5, 3'h0, 1'b0, 1'b0, 1'b0),
                     capw(8'h03, 6'h02, 3'h5, 3'h0, 1'b0, 1'b0, 1'b0));
      end
      // Shared reference clock picks the shorter latency
      wr(12'h050, 32'hFFFF_FFFF);
      rd(12'h04c, capw(8'h00, 6'h02, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0),
                  capw(8'h03, 6'h02, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0));
      chk({30'h0, shareDn, shareUp}, 32'h0000_0003);
      rd(12'h050, 32'h0000_0040, 32'h0000_0040);
      @(posedge clk);
      #1;
      chk(rdUp, 32'h0000_0000);
      chk(rdDn, 32'h0000_0000);
      // Relocked: writes dropped again
      wr(12'h400, 32'h0000_0000);
      wr(12'h04c, 32'h0000_7F80);
      rd(12'h04c, capw(8'h00, 6'h02, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0),
                  capw(8'h03, 6'h02, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0));
      // Reset in mid-run restores the built values, upstream width back from x2 to x4
      doReset();
      rd(12'h04c, rows[0].expUp, rows[0].expDn);
      rd(12'h400, 32'h0000_0000, 32'h0000_0000);
      stop_test();
   end

endmodule : link_capabilities_register_tb

//--- rtl/lcap_pkg.sv
// Constants and types for the link capability register bank
package lcap_pkg;

   // Register bus geometry
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;

   // Register byte offsets
   localparam logic [11:0] OFF_LINK_CAP    = 12'h04c;
   localparam logic [11:0] OFF_LINK_CTL    = 12'h050;
   localparam logic [11:0] OFF_UNLOCK      = 12'h400;

   // Field positions in the control registers
   localparam int          SHARED_REFCLK_CONFIG_BIT        = 6;
   localparam int          UNLOCK_BIT      = 0;

   // Supported speed codes
   localparam logic [3:0]  SPEED_GEN1      = 4'h1;
   localparam logic [3:0]  SPEED_GEN2      = 4'h2;

   // Lane width encodings
   localparam logic [5:0]  LANE_X1         = 6'h01;
   localparam logic [5:0]  LANE_X2         = 6'h02;
   localparam logic [5:0]  LANE_X4         = 6'h04;

   // Power state support and exit latency codes
   localparam logic [1:0]  ASPM_BOTH       = 2'h3;
   localparam logic [2:0]  SHORT_LAT_SEP   = 3'h5;
   localparam logic [2:0]  SHORT_LAT_SHARE = 3'h3;
   localparam logic [2:0]  DEEP_LAT_RST    = 3'h2;

   // Reset values of the single-bit capabilities and control bits
   localparam logic        REFCLK_RST      = 1'b0;
   localparam logic        DOWN_CAP_RST    = 1'b1;
   localparam logic        UP_CAP_VAL      = 1'b0;
   localparam logic        SHARED_REFCLK_CONFIG_RST        = 1'b0;
   localparam logic        UNLOCK_RST      = 1'b0;

   // Port numbering and zero fill values
   localparam logic [7:0]  PORT_UPSTREAM   = 8'h00;
   localparam logic [2:0]  RSVD_ZERO       = 3'h0;
   localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;

   // Layout of the link capability word, msb first
   typedef struct packed {
      logic [7:0] portIndex;
      logic [2:0] rsvd;
      logic       linkActiveReportCap;
      logic       surpriseDownReportCap;
      logic       refclkRemovalCapable;
      logic [2:0] deepStateExitLatency;
      logic [2:0] shortExitLatency;
      logic [1:0] activePowerStateSupport;
      logic [5:0] maxLaneCount;
      logic [3:0] supportedSpeedCode;
   } lcap_cap_s;

   // Lane encodings that the port can train at
   function automatic logic lcap_lane_valid(input logic [5:0] code);
      lcap_lane_valid = (code == LANE_X1) || (code == LANE_X2) || (code == LANE_X4);
   endfunction : lcap_lane_valid

endpackage : lcap_pkg

//--- rtl/lcap_regs.sv
// Link capability register bank of one switch port with its control bits
//
// Contract
// - The speed field in bits 3:0 is a constant reading 1 (2.5 Gbps); other codes are reserved.
// - The lane width field in bits 9:4 knows 1, 2 and 4 lanes as valid and all else as reserved.
// - On the upstream port software may write the lane width to force a narrower training width.
// - A reserved or invalid lane width makes the port act as if one lane were programmed.
// - At reset the lane width loads the width the port is physically built with.
// - The power state support field in bits 11:10 always reads 3.
// - The short exit latency reads 5 with separate reference clocks and 3 with a shared one.
// - The deep state exit latency in bits 17:15 resets to 2.
// - The reference clock removal bit 18 resets to zero.
// - Surprise-down reporting bit 19 resets to 1 downstream and stays 0 upstream.
// - Link-active reporting bit 20 resets to 1 downstream and is 0 upstream.
// - The top byte reads the port number, 0 upstream and 2 to 5 downstream.
// - The shared reference clock bit 6 of link control picks the short exit latency reported.

`timescale 1ns/1ps

module lcap_regs
   import lcap_pkg::*;
#(
   parameter logic [7:0] PORT_INDEX = PORT_UPSTREAM,
   parameter logic [5:0] PHYS_LANES = LANE_X1
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [DATA_W-1:0] regRdata,
   output logic      [5:0]        trainLaneCount,
   output logic                   sharedRefclk
);

   // Port role is fixed at build time
   localparam logic IS_UPSTREAM = (PORT_INDEX == PORT_UPSTREAM);
   localparam logic SD_RST      = IS_UPSTREAM ? UP_CAP_VAL : DOWN_CAP_RST;
   localparam logic DLL_RST     = IS_UPSTREAM ? UP_CAP_VAL : DOWN_CAP_RST;

   logic [1:0]        rstPipe_ff;
   logic              rstN;
   logic [5:0]        laneCount_ff;
   logic [2:0]        deepLat_ff;
   logic              refclkCap_ff;
   logic              sdCap_ff;
   logic              dllCap_ff;
   logic              shared_refclk_config_ff;
   logic              unlock_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [5:0]        trainLane_ff;
   logic              wrCap;
   logic              wrCtl;
   logic              wrUnlock;
   logic              capWrite;
   lcap_cap_s         wrFields;
   lcap_cap_s         capWord;
   logic [2:0]        shortLat;

   // Reset release through two flops so all state leaves reset on one edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstPipe_ff <= 2'h0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end

   assign rstN = rstPipe_ff[1];

   // Write decode; unmapped writes fall through and change nothing
   assign wrCap    = regWr && (regAddr == OFF_LINK_CAP);
   assign wrCtl    = regWr && (regAddr == OFF_LINK_CTL);
   assign wrUnlock = regWr && (regAddr == OFF_UNLOCK);
   assign capWrite = wrCap && unlock_ff;
   assign wrFields = lcap_cap_s'(regWdata);

   // Register unlock control, gates every lockable field
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         unlock_ff <= UNLOCK_RST;
      end else if (wrUnlock) begin
         unlock_ff <= regWdata[UNLOCK_BIT];
      end
   end

   // Shared reference clock selection in link control
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         shared_refclk_config_ff <= SHARED_REFCLK_CONFIG_RST;
      end else if (wrCtl) begin
         shared_refclk_config_ff <= regWdata[SHARED_REFCLK_CONFIG_BIT];
      end
   end

   // Lane width: built width at reset, upstream override when unlocked
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         laneCount_ff <= PHYS_LANES;
      end else if (capWrite && IS_UPSTREAM) begin
         laneCount_ff <= wrFields.maxLaneCount;
      end
   end

   // Width handed to training; reserved codes are held as stored but train at x1
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         trainLane_ff <= LANE_X1;
      end else if (lcap_lane_valid(laneCount_ff)) begin
         trainLane_ff <= laneCount_ff;
      end else begin
         trainLane_ff <= LANE_X1;
      end
   end

   // Deep state exit latency, lockable
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         deepLat_ff <= DEEP_LAT_RST;
      end else if (capWrite) begin
         deepLat_ff <= wrFields.deepStateExitLatency;
      end
   end

   // Reference clock removal capability, lockable
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         refclkCap_ff <= REFCLK_RST;
      end else if (capWrite) begin
         refclkCap_ff <= wrFields.refclkRemovalCapable;
      end
   end

   // Reporting capabilities; upstream keeps both at zero whatever is written
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sdCap_ff  <= SD_RST;
         dllCap_ff <= DLL_RST;
      end else if (capWrite && !IS_UPSTREAM) begin
         sdCap_ff  <= wrFields.surpriseDownReportCap;
         dllCap_ff <= wrFields.linkActiveReportCap;
      end
   end

   // Short exit latency follows the clocking mode, never stored
   assign shortLat = shared_refclk_config_ff ? SHORT_LAT_SHARE : SHORT_LAT_SEP;

   // Assemble the capability word from constants and live state
   always_comb begin
      capWord                         = '0;
      capWord.supportedSpeedCode      = SPEED_GEN1;
      capWord.maxLaneCount            = laneCount_ff;
      capWord.activePowerStateSupport = ASPM_BOTH;
      capWord.shortExitLatency        = shortLat;
      capWord.deepStateExitLatency    = deepLat_ff;
      capWord.refclkRemovalCapable    = refclkCap_ff;
      capWord.surpriseDownReportCap   = sdCap_ff;
      capWord.linkActiveReportCap     = dllCap_ff;
      capWord.rsvd                    = RSVD_ZERO;
      capWord.portIndex               = PORT_INDEX;
   end

   // Read mux; unmapped addresses answer zero
   always_comb begin
      nxt_rdata = DATA_ZERO;
      if (regRd) begin
         case (regAddr)
            OFF_LINK_CAP: begin
               nxt_rdata = capWord;
            end
            OFF_LINK_CTL: begin
               nxt_rdata[SHARED_REFCLK_CONFIG_BIT] = shared_refclk_config_ff;
            end
            OFF_UNLOCK: begin
               nxt_rdata[UNLOCK_BIT] = unlock_ff;
            end
            default: begin
               nxt_rdata = DATA_ZERO;
            end
         endcase
      end
   end

   // Read data stand for one cycle only, zero otherwise
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdata_ff <= DATA_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign regRdata       = rdata_ff;
   assign trainLaneCount = trainLane_ff;
   assign sharedRefclk   = shared_refclk_config_ff;

   // Checks on the register bank
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstN);

   logic capRead;
   assign capRead = regRd && (regAddr == OFF_LINK_CAP);

   // Read decode of the other places, for the checks below
   logic ctlRead;
   logic unlockRead;
   logic unmappedRead;
   assign ctlRead      = regRd && (regAddr == OFF_LINK_CTL);
   assign unlockRead   = regRd && (regAddr == OFF_UNLOCK);
   assign unmappedRead = regRd && !capRead && !ctlRead && !unlockRead;

   a_speed_reads_gen1: assert property (
      capRead |=> (regRdata[3:0] == SPEED_GEN1))
      else $error("speed field not gen1");

   a_lane_valid_pass: assert property (
      (rstN && lcap_lane_valid(laneCount_ff)) |=> (trainLaneCount == $past(laneCount_ff)))
      else $error("valid lane width not used");

   a_lane_upstream_write: assert property (
      (capWrite && IS_UPSTREAM) |=> (laneCount_ff == $past(regWdata[9:4])))
      else $error("upstream lane write lost");

   a_lane_invalid_x1: assert property (
      (!lcap_lane_valid(laneCount_ff)) [*2] |-> (trainLaneCount == LANE_X1))
      else $error("invalid lane width not trained at x1");

   a_lane_built_width: assert property (
      $rose(rstN) |-> (laneCount_ff == PHYS_LANES))
      else $error("lane width not built width at reset");

   a_power_support: assert property (
      capRead |=> (regRdata[11:10] == ASPM_BOTH))
      else $error("power state support not 3");

   a_short_latency: assert property (
      capRead |=> (regRdata[14:12] == ($past(shared_refclk_config_ff) ? SHORT_LAT_SHARE : SHORT_LAT_SEP)))
      else $error("short exit latency wrong for clock mode");

   a_deep_latency_rst: assert property (
      $rose(rstN) |-> (deepLat_ff == DEEP_LAT_RST))
      else $error("deep exit latency reset wrong");

   a_refclk_rst: assert property (
      $rose(rstN) |-> (refclkCap_ff == REFCLK_RST))
      else $error("refclk removal bit reset wrong");

   a_surprise_down: assert property (
      $rose(rstN) |-> (sdCap_ff == SD_RST) && (!IS_UPSTREAM || !sdCap_ff))
      else $error("surprise down bit wrong");

   a_link_active: assert property (
      IS_UPSTREAM |-> !dllCap_ff && !sdCap_ff)
      else $error("upstream reporting bit set");

   a_port_number: assert property (
      capRead |=> (regRdata[31:24] == PORT_INDEX))
      else $error("port number wrong");

   a_shared_refclk_config_selects: assert property (
      (wrCtl ##1 capRead) |=> (regRdata[14:12] ==
         ($past(regWdata[SHARED_REFCLK_CONFIG_BIT], 2) ? SHORT_LAT_SHARE : SHORT_LAT_SEP)))
      else $error("shared clock bit did not steer latency");

   a_locked_hold: assert property (
      (wrCap && !unlock_ff) |=> $stable(deepLat_ff) && $stable(laneCount_ff)
         && $stable(refclkCap_ff))
      else $error("locked field changed");

   a_reserved_zero: assert property (
      regRd |=> (regRdata[23:21] == RSVD_ZERO))
      else $error("reserved bits not zero");

   a_rdata_idle: assert property (
      !regRd |=> (regRdata == DATA_ZERO))
      else $error("read data outside read slot");

   a_lane_readback: assert property (
      capRead |=> (regRdata[9:4] == $past(laneCount_ff)))
      else $error("lane width readback wrong");

   a_lane_down_fixed: assert property (
      !IS_UPSTREAM |-> (laneCount_ff == PHYS_LANES))
      else $error("downstream lane width changed");

   a_deep_latency_wr: assert property (
      capWrite |=> (deepLat_ff == $past(regWdata[17:15])))
      else $error("unlocked deep latency write lost");

   a_refclk_wr: assert property (
      capWrite |=> (refclkCap_ff == $past(regWdata[18])))
      else $error("unlocked refclk bit write lost");

   a_locked_reports: assert property (
      (wrCap && !unlock_ff) |=> $stable(sdCap_ff) && $stable(dllCap_ff))
      else $error("locked reporting bit changed");

   a_down_report_wr: assert property (
      (capWrite && !IS_UPSTREAM) |=> (sdCap_ff == $past(regWdata[19]))
         && (dllCap_ff == $past(regWdata[20])))
      else $error("downstream reporting write lost");

   a_upstream_report_read: assert property (
      (capRead && IS_UPSTREAM) |=> (regRdata[20:19] == 2'h0))
      else $error("upstream reporting bits read set");

   a_deep_latency_read: assert property (
      capRead |=> (regRdata[17:15] == $past(deepLat_ff)))
      else $error("deep latency readback wrong");

   a_refclk_read: assert property (
      capRead |=> (regRdata[18] == $past(refclkCap_ff)))
      else $error("refclk bit readback wrong");

   a_ctl_readback: assert property (
      ctlRead |=> (regRdata[SHARED_REFCLK_CONFIG_BIT] == $past(shared_refclk_config_ff)) && (regRdata[SHARED_REFCLK_CONFIG_BIT-1:0] == '0)
         && (regRdata[DATA_W-1:SHARED_REFCLK_CONFIG_BIT+1] == '0))
      else $error("link control readback wrong");

   a_shared_follows: assert property (
      wrCtl |=> (sharedRefclk == $past(regWdata[SHARED_REFCLK_CONFIG_BIT])))
      else $error("shared clock output not updated");

   a_unlock_write: assert property (
      wrUnlock |=> (unlock_ff == $past(regWdata[UNLOCK_BIT])))
      else $error("unlock write lost");

   a_unlock_readback: assert property (
      unlockRead |=> (regRdata[UNLOCK_BIT] == $past(unlock_ff))
         && ($countones(regRdata) <= 1))
      else $error("unlock readback wrong");

   a_unmapped_zero: assert property (
      unmappedRead |=> (regRdata == DATA_ZERO))
      else $error("unmapped read not zero");

   // Main scenarios
   c_unlocked_write: cover property (wrUnlock ##[1:4] capWrite ##1 capRead);
   c_invalid_lane: cover property (capWrite && !lcap_lane_valid(regWdata[9:4]));
   c_shared_clock: cover property (wrCtl && regWdata[SHARED_REFCLK_CONFIG_BIT] ##1 capRead);
   c_back_to_back: cover property (regWr ##1 regRd ##1 regRd);
   c_relock: cover property (wrUnlock && !regWdata[UNLOCK_BIT] ##1 wrCap);

endmodule : lcap_regs
